// File: include/dpdc_pkg.sv
// Constants and types for the per-channel power-down controller
// Assumes one clock at 40 MHz and a plain register port from the serial command decoder
package dpdc_pkg;
   typedef enum logic [1:0] {
      DPDC_MODE_NORMAL = 2'h0,
      DPDC_MODE_PD1K   = 2'h1,
      DPDC_MODE_PD125K = 2'h2,
      DPDC_MODE_OPEN   = 2'h3
   } dpdc_mode_e;

   typedef enum logic [1:0] {
      DPDC_ST_ON      = 2'h0,
      DPDC_ST_ENTER   = 2'h1,
      DPDC_ST_DOWN    = 2'h2,
      DPDC_ST_EXIT    = 2'h3
   } dpdc_state_e;

   // Register offsets on the command port
   localparam logic [3:0] DPDC_VOL_PWRDN_ADDR = 4'h0;
   localparam logic [3:0] DPDC_NV_PWRDN_ADDR  = 4'h1;
   localparam logic [3:0] DPDC_STATUS_ADDR    = 4'h2;
   localparam logic [3:0] DPDC_CMD_ADDR       = 4'h3;

   // Command register bit positions
   localparam int DPDC_CMD_GC_RESET_BIT = 0;
   localparam int DPDC_CMD_GC_WAKE_BIT  = 1;
   localparam int DPDC_CMD_HV_WRITE_BIT = 2;

   // Reset value of nonvolatile copy
   localparam logic [15:0] DPDC_NV_PWRDN_RESET = 16'h0000;

   // Delays in nanoseconds and derived cycle counts at 40 MHz
   localparam int DPDC_CLK_PERIOD_NS  = 25;
   localparam int DPDC_ENTRY_DELAY_NS = 10000;
   localparam int DPDC_EXIT_DELAY_NS  = 10000;
   localparam int DPDC_ENTRY_CYCLES   =
      (DPDC_ENTRY_DELAY_NS + DPDC_CLK_PERIOD_NS - 1) / DPDC_CLK_PERIOD_NS;
   localparam int DPDC_EXIT_CYCLES    =
      (DPDC_EXIT_DELAY_NS + DPDC_CLK_PERIOD_NS - 1) / DPDC_CLK_PERIOD_NS;
   localparam int DPDC_CNT_W          = 16;
endpackage

// File: rtl/dpdc_channel_seq.sv
// One channel's power-down sequencer
// Assumes mode field comes from the register file in the same clock domain
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module dpdc_channel_seq
   import dpdc_pkg::*;
#(
   parameter int ENTRY_CYCLES = DPDC_ENTRY_CYCLES,
   parameter int EXIT_CYCLES  = DPDC_EXIT_CYCLES
)
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic [1:0] modeField,
   output logic            ampEnable,
   output logic            ladderEnable,
   output logic            refConnect,
   output logic            pullDown1k,
   output logic            pullDown125k,
   output logic            inPowerDown
);
   dpdc_state_e             state_reg;
   dpdc_state_e             state_next;
   logic [DPDC_CNT_W-1:0]   count_reg;
   logic [DPDC_CNT_W-1:0]   count_next;
   logic                    ampEnable_reg;
   logic                    ampEnable_next;
   logic                    ladderEnable_reg;
   logic                    ladderEnable_next;
   logic                    pull1k_reg;
   logic                    pull1k_next;
   logic                    pull125k_reg;
   logic                    pull125k_next;

   always_comb
   begin
      state_next        = state_reg;
      count_next        = count_reg;
      ampEnable_next    = ampEnable_reg;
      ladderEnable_next = ladderEnable_reg;
      pull1k_next       = pull1k_reg;
      pull125k_next     = pull125k_reg;
      case (state_reg)
         DPDC_ST_ON:
         begin
            ampEnable_next    = 1'b1;
            ladderEnable_next = 1'b1;
            pull1k_next       = 1'b0;
            pull125k_next     = 1'b0;
            if (modeField != DPDC_MODE_NORMAL)
            begin
               state_next  = DPDC_ST_ENTER;
               count_next  = DPDC_CNT_W'(ENTRY_CYCLES);
            end
         end
         DPDC_ST_ENTER:
         begin
            if (modeField == DPDC_MODE_NORMAL)
               state_next = DPDC_ST_ON;
            else if (count_reg <= 16'h0001)
            begin
               state_next        = DPDC_ST_DOWN;
               ampEnable_next    = 1'b0;
               ladderEnable_next = 1'b0;
               pull1k_next       = (modeField == DPDC_MODE_PD1K);
               pull125k_next     = (modeField == DPDC_MODE_PD125K);
            end
            else
               count_next = count_reg - 16'h0001;
         end
         DPDC_ST_DOWN:
         begin
            pull1k_next   = (modeField == DPDC_MODE_PD1K);
            pull125k_next = (modeField == DPDC_MODE_PD125K);
            if (modeField == DPDC_MODE_NORMAL)
            begin
               state_next        = DPDC_ST_EXIT;
               count_next        = DPDC_CNT_W'(EXIT_CYCLES);
               ladderEnable_next = 1'b1;
               pull1k_next       = 1'b0;
               pull125k_next     = 1'b0;
            end
         end
         DPDC_ST_EXIT:
         begin
            if (modeField != DPDC_MODE_NORMAL)
            begin
               state_next        = DPDC_ST_DOWN;
               ladderEnable_next = 1'b0;
            end
            else if (count_reg <= 16'h0001)
            begin
               state_next     = DPDC_ST_ON;
               ampEnable_next = 1'b1;
            end
            else
               count_next = count_reg - 16'h0001;
         end
         default:
            state_next = DPDC_ST_ON;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg        <= DPDC_ST_ON;
         count_reg        <= 16'h0000;
         ampEnable_reg    <= 1'b1;
         ladderEnable_reg <= 1'b1;
         pull1k_reg       <= 1'b0;
         pull125k_reg     <= 1'b0;
      end
      else
      begin
         state_reg        <= state_next;
         count_reg        <= count_next;
         ampEnable_reg    <= ampEnable_next;
         ladderEnable_reg <= ladderEnable_next;
         pull1k_reg       <= pull1k_next;
         pull125k_reg     <= pull125k_next;
      end
   end

   assign ampEnable    = ampEnable_reg;
   assign ladderEnable = ladderEnable_reg;
   assign refConnect   = ladderEnable_reg;
   assign pullDown1k   = pull1k_reg;
   assign pullDown125k = pull125k_reg;
   assign inPowerDown  = (state_reg == DPDC_ST_DOWN);
endmodule

// File: rtl/dac_power_down_control.sv
// Top of the per-channel power-down controller with its register port
// Assumes a command decoder drives the register port; analogue switches take the enables
`timescale 1ns/1ps
module dac_power_down_control
   import dpdc_pkg::*;
#(
   parameter int CHANNELS     = 8,
   parameter int ENTRY_CYCLES = DPDC_ENTRY_CYCLES,
   parameter int EXIT_CYCLES  = DPDC_EXIT_CYCLES
)
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic [3:0]            regAddr,
   input  wire logic [15:0]           regWdata,
   input  wire logic                  regWrite,
   input  wire logic                  regRead,
   output logic [15:0]                regRdata,
   output logic [CHANNELS-1:0]        ampEnable,
   output logic [CHANNELS-1:0]        ladderEnable,
   output logic [CHANNELS-1:0]        refConnect,
   output logic [CHANNELS-1:0]        pullDown1k,
   output logic [CHANNELS-1:0]        pullDown125k
);
   logic [2*CHANNELS-1:0] volPd_reg;
   logic [2*CHANNELS-1:0] volPd_next;
   logic [2*CHANNELS-1:0] nvPd_reg;
   logic [2*CHANNELS-1:0] nvPd_next;
   logic                  recall_reg;
   logic                  recall_next;
   logic [15:0]           rdata_reg;
   logic [15:0]           rdata_next;
   logic [CHANNELS-1:0]   downFlags;

   function automatic logic [2*CHANNELS-1:0] fit(input logic [15:0] v);
      fit = v[2*CHANNELS-1:0];
   endfunction

   // Volatile field, nonvolatile copy and recall; the register port is never gated by
   // power-down, so commands always reach here
   always_comb
   begin
      volPd_next  = volPd_reg;
      nvPd_next   = nvPd_reg;
      recall_next = 1'b0;
      if (recall_reg)
         volPd_next = nvPd_reg;
      if (regWrite)
      begin
         case (regAddr)
            DPDC_VOL_PWRDN_ADDR:
               volPd_next = fit(regWdata);
            DPDC_NV_PWRDN_ADDR:
               nvPd_next = fit(regWdata);
            DPDC_CMD_ADDR:
            begin
               if (regWdata[DPDC_CMD_GC_RESET_BIT])
                  volPd_next = nvPd_reg;
               else if (regWdata[DPDC_CMD_GC_WAKE_BIT])
                  volPd_next = '0;
               else if (regWdata[DPDC_CMD_HV_WRITE_BIT])
                  volPd_next = fit(regWdata);
            end
            default:
               volPd_next = volPd_reg;
         endcase
      end
   end

   always_comb
   begin
      rdata_next = 16'h0000;
      if (regRead)
      begin
         case (regAddr)
            DPDC_VOL_PWRDN_ADDR: rdata_next = 16'(volPd_reg);
            DPDC_NV_PWRDN_ADDR:  rdata_next = 16'(nvPd_reg);
            DPDC_STATUS_ADDR:    rdata_next = 16'(downFlags);
            default:             rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         volPd_reg  <= '0;
         nvPd_reg   <= DPDC_NV_PWRDN_RESET[2*CHANNELS-1:0];
         recall_reg <= 1'b1;
         rdata_reg  <= 16'h0000;
      end
      else
      begin
         volPd_reg  <= volPd_next;
         nvPd_reg   <= nvPd_next;
         recall_reg <= recall_next;
         rdata_reg  <= rdata_next;
      end
   end

   assign regRdata = rdata_reg;

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++)
      begin : g_chan
         dpdc_channel_seq #(
            .ENTRY_CYCLES (ENTRY_CYCLES),
            .EXIT_CYCLES  (EXIT_CYCLES)
         ) u_seq (
            .clk_sys      (clk_sys),
            .rst_n        (rst_n),
            .modeField    (volPd_reg[2*ch +: 2]),
            .ampEnable    (ampEnable[ch]),
            .ladderEnable (ladderEnable[ch]),
            .refConnect   (refConnect[ch]),
            .pullDown1k   (pullDown1k[ch]),
            .pullDown125k (pullDown125k[ch]),
            .inPowerDown  (downFlags[ch])
         );
      end
   endgenerate
endmodule

// File: sim/dpdc_master_model.sv
// Command-side master model for the register port
// Assumes the bench calls its tasks; it drives only after rising edges
`timescale 1ns/1ps
module dpdc_master_model
   import dpdc_pkg::*;
(
   input  wire logic   clk_sys,
   output logic [3:0]  regAddr,
   output logic [15:0] regWdata,
   output logic        regWrite,
   output logic        regRead
);
   initial
   begin
      regAddr = 4'h0;
      regWdata = 16'h0000;
      regWrite = 1'b0;
      regRead = 1'b0;
   end
   // Released address and data show the inverse of the last value
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      regAddr <= ~a;
      regWdata <= ~d;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      regAddr <= ~a;
   endtask
   // Wake-up is always followed by a reset
   task automatic wake_reset;
      wr(DPDC_CMD_ADDR, 16'h0002);
      repeat (20) @(posedge clk_sys);
      wr(DPDC_CMD_ADDR, 16'h0001);
   endtask
endmodule

// File: sim/dpdc_checker_assertions.sv
// Port checker for the power-down controller
// Assumes it is bound onto every controller instance
`timescale 1ns/1ps
module dpdc_checker
   import dpdc_pkg::*;
#(
   parameter int CHANNELS     = 8,
   parameter int ENTRY_CYCLES = DPDC_ENTRY_CYCLES,
   parameter int EXIT_CYCLES  = DPDC_EXIT_CYCLES
)
(
   input wire logic                clk_sys,
   input wire logic                rst_n,
   input wire logic [3:0]          regAddr,
   input wire logic [15:0]         regWdata,
   input wire logic                regWrite,
   input wire logic                regRead,
   input wire logic [15:0]         regRdata,
   input wire logic [CHANNELS-1:0] ampEnable,
   input wire logic [CHANNELS-1:0] ladderEnable,
   input wire logic [CHANNELS-1:0] refConnect,
   input wire logic [CHANNELS-1:0] pullDown1k,
   input wire logic [CHANNELS-1:0] pullDown125k
);
   localparam int ENTRY_MAX = ENTRY_CYCLES + 3;
   localparam int EXIT_MAX  = EXIT_CYCLES + 3;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence volWr0;
      regWrite && regAddr == DPDC_VOL_PWRDN_ADDR && regWdata[1:0] != 2'h0 && ampEnable[0];
   endsequence
   sequence exitStart;
      $rose(ladderEnable[0]);
   endsequence
   ref_tracks_ladder_a: assert property (refConnect == ladderEnable)
      else $error("reference link differs from ladder");
   pull_vs_amp_a: assert property ((ampEnable & (pullDown1k | pullDown125k)) == '0)
      else $error("pull-down while amplifier drives");
   pull_exclusive_a: assert property ((pullDown1k & pullDown125k) == '0)
      else $error("both pull-downs selected");
   rdata_idle_a: assert property (!regRead |=> regRdata == 16'h0000)
      else $error("read data outside answer cycle");
   entry_hold_a: assert property (volWr0 |=> ampEnable[0] [*2])
      else $error("amplifier stopped without entry delay");
   entry_done_a: assert property (volWr0 ##0 regWdata[1:0] == 2'h1 |->
      ##[2:ENTRY_MAX] (pullDown1k[0] && !ladderEnable[0]))
      else $error("entry did not complete");
   exit_wait_a: assert property (exitStart |-> !ampEnable[0] [*2])
      else $error("amplifier drove without exit delay");
   exit_done_a: assert property (exitStart |-> ##[1:EXIT_MAX] ampEnable[0])
      else $error("exit did not complete");
   wake_all_a: assert property (regWrite && regAddr == DPDC_CMD_ADDR &&
      regWdata[2:0] == 3'h2 |-> ##[1:EXIT_MAX] (&ampEnable))
      else $error("wake-up left a channel down");
endmodule
bind dac_power_down_control dpdc_checker #(.CHANNELS(CHANNELS), .ENTRY_CYCLES(ENTRY_CYCLES),
   .EXIT_CYCLES(EXIT_CYCLES)) dpdc_checker_inst (.clk_sys(clk_sys), .rst_n(rst_n),
   .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
   .regRdata(regRdata), .ampEnable(ampEnable), .ladderEnable(ladderEnable),
   .refConnect(refConnect), .pullDown1k(pullDown1k), .pullDown125k(pullDown125k));

// File: sim/tb.sv
// Self-checking bench for the power-down controller
// Assumes the master model drives the register port
`timescale 1ns/1ps
module tb
   import dpdc_pkg::*;
;
   logic        clk_sys;
   logic        rst_n;
   logic [3:0]  regAddr;
   logic [15:0] regWdata;
   logic        regWrite;
   logic        regRead;
   logic [15:0] regRdata;
   logic [7:0]  ampEnable;
   logic [7:0]  ladderEnable;
   logic [7:0]  refConnect;
   logic [7:0]  pullDown1k;
   logic [7:0]  pullDown125k;
   logic        rdPend;
   logic [15:0] expQ[$];
   logic [15:0] hv;
   int          errors;
   int          n_checks;
   int          seed;
   dac_power_down_control #(.CHANNELS(8), .ENTRY_CYCLES(4), .EXIT_CYCLES(4))
      dac_power_down_control_inst (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .ampEnable(ampEnable), .ladderEnable(ladderEnable), .refConnect(refConnect),
      .pullDown1k(pullDown1k), .pullDown125k(pullDown125k));
   dpdc_master_model dpdc_master_model_inst (.clk_sys(clk_sys), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (expQ.size() != 0)
         errors++;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      dpdc_master_model_inst.wr(a, d);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      expQ.push_back(e);
      dpdc_master_model_inst.rd(a);
   endtask
   // Lets sequencing finish, then samples all enables mid-cycle
   task automatic outs(input logic [7:0] on, input logic [7:0] p1, input logic [7:0] p2);
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({8'h00, ampEnable}, {8'h00, on});
      chk({8'h00, ladderEnable}, {8'h00, on});
      chk({8'h00, refConnect}, {8'h00, on});
      chk({8'h00, pullDown1k}, {8'h00, p1});
      chk({8'h00, pullDown125k}, {8'h00, p2});
   endtask
   always @(posedge clk_sys)
   begin
      if (rdPend === 1'b1)
         chk(regRdata, expQ.pop_front());
      rdPend <= regRead;
   end
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      errors++;
      tally_and_finish;
   end
   initial
   begin
      errors = 0;
      n_checks = 0;
      seed = 32'h90AE;
      rst_n = 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(DPDC_VOL_PWRDN_ADDR, DPDC_NV_PWRDN_RESET);
      wr(DPDC_VOL_PWRDN_ADDR, 16'hE4E4);
      outs(8'h11, 8'h22, 8'h44);
      rd(DPDC_STATUS_ADDR, 16'h00EE);
      wr(4'h9, 16'h0000);
      rd(4'h9, 16'h0000);
      rd(DPDC_VOL_PWRDN_ADDR, 16'hE4E4);
      wr(DPDC_NV_PWRDN_ADDR, 16'h0005);
      rd(DPDC_NV_PWRDN_ADDR, 16'h0005);
      dpdc_master_model_inst.wake_reset();
      outs(8'hFC, 8'h03, 8'h00);
      rd(DPDC_VOL_PWRDN_ADDR, 16'h0005);
      hv = 16'($random(seed));
      hv[3:0] = 4'h4;
      wr(DPDC_CMD_ADDR, hv);
      rd(DPDC_VOL_PWRDN_ADDR, hv);
      wr(DPDC_VOL_PWRDN_ADDR, 16'h0000);
      outs(8'hFF, 8'h00, 8'h00);
      wr(DPDC_VOL_PWRDN_ADDR, 16'h5555);
      outs(8'h00, 8'hFF, 8'h00);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      outs(8'hFF, 8'h00, 8'h00);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(DPDC_VOL_PWRDN_ADDR, DPDC_NV_PWRDN_RESET);
      repeat (3) @(posedge clk_sys);
      tally_and_finish;
   end
endmodule
